// >>> test/slcs_peer.sv
// Peer sublayer model: returns the code-group stream with lane skew
`timescale 1ns/10ps
`default_nettype none
module slcs_peer (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [3:0] from_dut,
  input  wire logic       jam,
  output logic [3:0]      to_dut
);
  logic [7:0] dly [4];  // Per-lane delay lines
  // Lanes lag by different bit counts, all below one code-group
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int l = 0; l < 4; l++)
        dly[l] <= 8'h55;
    end
    else
    begin
      for (int l = 0; l < 4; l++)
        dly[l] <= {dly[l][6:0], from_dut[l]};
    end
  end
  // Jam holds lane 0 high so whole code-groups turn invalid
  always_comb
  begin
    for (int l = 0; l < 4; l++)
      to_dut[l] = dly[l][2 * l] | (jam && l == 0);
  end
endmodule // slcs_peer
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the coding sublayer through a skewed peer
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch at %0t: %h %h", $time, (a), (b)); end end
module tb;
  logic       clk = 1'b0;       // 250 MHz clock
  logic       nrst = 1'b0;      // Reset, active low
  logic       force_1x = 1'b0;  // One-lane request
  logic [7:0] tx_data = 8'h00;  // Offered byte
  logic       tx_is_k = 1'b0;   // Offered flag
  logic       tx_valid = 1'b0;  // Offer strobe
  logic       jam = 1'b0;       // Lane 0 corruption
  logic       tx_ready, rx_is_k, rx_invalid, rx_valid, mode_4x, link_up;
  logic [3:0] tx_serial, rx_serial, lane_sync;
  logic [7:0] rx_data;
  logic [8:0] got [$];          // Delivered characters
  int         n_fail = 0;
  int         total_checks = 0;
  int         n_inv = 0;        // Invalid deliveries
  // Specials that carry no comma and are not idle
  localparam logic [8:0] KSET [8] = '{9'h11c, 9'h15c, 9'h17c, 9'h19c,
    9'h1dc, 9'h1f7, 9'h1fd, 9'h1fe};
  always #2 clk = ~clk;
  slcs_top uut (.clk(clk), .nrst(nrst), .force_1x(force_1x), .tx_data(tx_data),
    .tx_is_k(tx_is_k), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_serial(tx_serial),
    .rx_serial(rx_serial), .rx_data(rx_data), .rx_is_k(rx_is_k), .rx_invalid(rx_invalid),
    .rx_valid(rx_valid), .lane_sync(lane_sync), .mode_4x(mode_4x), .link_up(link_up));
  slcs_peer peer (.clk(clk), .nrst(nrst), .from_dut(tx_serial), .jam(jam),
    .to_dut(rx_serial));
  // Collect delivered characters away from the edge that launches them
  always @(negedge clk)
  begin
    if (rx_valid === 1'b1 && rx_invalid === 1'b1)
      n_inv++;
    else if (rx_valid === 1'b1)
      got.push_back({rx_is_k, rx_data});
  end
  task automatic wrap_up();
    if (n_fail == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic bit cond(int sel, int n);
    case (sel)
      0: return mode_4x === 1'b1;
      1: return mode_4x === 1'b0;
      2: return got.size() >= n;
      3: return n_inv > 0;
      default: return link_up === 1'b1;
    endcase
  endfunction
  // Bounded wait; a hang counts as a mismatch
  task automatic wait_for(input int sel, input int n, input int lim);
    int c;
    c = 0;
    while (!cond(sel, n) && c < lim)
    begin
      @(negedge clk);
      c++;
    end
    if (c >= lim)
    begin
      n_fail++;
      wrap_up();
    end
  endtask
  // Every lane shows the sync code-group, bit a first
  task automatic t_idle();
    logic [9:0] w [4];
    logic [3:0] seen;
    seen = 4'h0;
    for (int l = 0; l < 4; l++)
      w[l] = 10'h000;
    repeat (60)
    begin
      @(negedge clk);
      for (int l = 0; l < 4; l++)
      begin
        w[l] = {w[l][8:0], tx_serial[l]};
        if (w[l] == 10'h0fa || w[l] == 10'h305)
          seen[l] = 1'b1;
      end
    end
    `CHK(seen, 4'hf)
  endtask
  // Back-to-back characters return whole and in order
  task automatic t_stream(input int n, input bit spec, input logic full_exp);
    logic [8:0] exp [$];
    logic       full;
    int         i;
    int         g;
    full = 1'b0;
    i = 0;
    g = 0;
    got.delete();
    for (int k = 0; k < n; k++)
      exp.push_back(spec ? KSET[k % 8] : {1'b0, 8'(k * 37 + 5)});
    while (i < n && g < 4000)
    begin
      @(negedge clk);
      {tx_is_k, tx_data} = exp[i];
      tx_valid = 1'b1;
      g++;
      if (tx_ready === 1'b1)
        i++;
      else
        full = 1'b1;
    end
    @(negedge clk);
    tx_valid = 1'b0;
    // A queue that never took the whole burst counts as a failure
    if (i < n)
    begin
      n_fail++;
      wrap_up();
    end
    wait_for(2, n, 40 * n + 400);
    `CHK(full, full_exp)
    foreach (exp[k])
      `CHK(got[k], exp[k])
  endtask
  // Corrupt lane 0, expect invalid marks, then relock
  task automatic t_jam();
    n_inv = 0;
    @(negedge clk);
    jam = 1'b1;
    repeat (20) @(negedge clk);
    jam = 1'b0;
    wait_for(3, 0, 200);
    `CHK(n_inv > 0, 1'b1)
    wait_for(4, 0, 200);
    `CHK(link_up, 1'b1)
  endtask
  // Reset values, then word lock on every lane and four-lane mode
  task automatic t_reset();
    repeat (4) @(negedge clk);
    `CHK({tx_ready, tx_serial, rx_valid, lane_sync, mode_4x, link_up}, 12'h800)
    nrst = 1'b1;
    wait_for(0, 0, 600);
    `CHK(lane_sync, 4'hf)
    `CHK(link_up, 1'b1)
    `CHK(mode_4x, 1'b1)
  endtask
  // Request one lane and expect four-lane mode to drop
  task automatic t_narrow();
    force_1x = 1'b1;
    wait_for(1, 0, 20);
    `CHK(mode_4x, 1'b0)
  endtask
  // Main sequence
  initial
  begin
    t_reset();
    // Let two alignment columns pass before traffic
    repeat (400) @(negedge clk);
    t_idle();
    t_stream(8, 1'b1, 1'b0);
    t_stream(80, 1'b0, 1'b1);
    t_narrow();
    t_idle();
    t_stream(12, 1'b0, 1'b0);
    t_jam();
    t_stream(4, 1'b1, 1'b0);
    wrap_up();
  end
endmodule // tb
`default_nettype wire

// >>> verilog/slcs_fifo.sv
// First-word-fall-through FIFO with registered read data
`timescale 1ns/10ps
`default_nettype none
module slcs_fifo #(
  parameter int W = 9,
  parameter int D = 32
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_r [D];  // Storage, depth a power of two
  logic [AW-1:0] wp_r;       // Write pointer
  logic [AW-1:0] rp_r;       // Read pointer
  logic [AW:0]   cnt_r;      // Words held in storage
  logic          push;       // Word accepted
  logic          load;       // Word moved to the output register

  assign in_ready = (cnt_r != (AW+1)'(D));
  assign push     = in_valid && in_ready;
  assign load     = (cnt_r != '0) && (!out_valid || out_ready);

  // Storage write
  always_ff @(posedge clk)
  begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

  // Pointers and fill count
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (load)
        rp_r <= rp_r + 1'b1;
      if (push && !load)
        cnt_r <= cnt_r + 1'b1;
      else if (load && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end

  // Output register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (load)
    begin
      out_valid <= 1'b1;
      out_data  <= mem_r[rp_r];
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end
endmodule // slcs_fifo
`default_nettype wire

// >>> verilog/slcs_pkg.sv
// Shared constants for the serial lane coding sublayer
`default_nettype none
package slcs_pkg;
  // Lane count and character widths
  localparam int LANES     = 4;
  localparam int CHAR_W    = 9;   // Flag plus byte
  localparam int QCHAR_W   = 10;  // Invalid marker plus character
  localparam int CG_W      = 10;  // Code-group width
  // Clocks per code-group: one bit per clock on each lane
  localparam int CG_CYCLES = CG_W;
  // Buffer depths
  localparam int TXQ_DEPTH = 32;
  localparam int DSK_DEPTH = 8;
  // Idle content: sync character, alignment column every 16th idle column
  localparam logic [8:0] K_SYNC  = 9'h1bc;
  localparam logic [8:0] K_ALIGN = 9'h1fb;
  localparam int         IDLE_W  = 4;
  // Comma patterns in bits a..e,i,f order
  localparam logic [6:0] COMMA_P = 7'h1f;
  localparam logic [6:0] COMMA_N = 7'h60;
  // Running disparity value after reset (negative)
  localparam logic       RD_NEG  = 1'b0;
  // Six-bit sub-block, negative column, indexed by x
  localparam logic [5:0] ENC6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  // Six-bit sub-block for x = 28 of a special character
  localparam logic [5:0] K28_6B = 6'h0f;
  // Four-bit sub-block, negative column, indexed by y
  localparam logic [3:0] ENC4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  // Alternate four-bit sub-block for y = 7
  localparam logic [3:0] ENC4_A7 = 4'h7;
endpackage
`default_nettype wire

// >>> verilog/slcs_top.sv
// Coding and medium attachment sublayer for a one or four lane link
`timescale 1ns/10ps
`default_nettype none
module slcs_top (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       force_1x,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_is_k,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [3:0]      tx_serial,
  input  wire logic [3:0] rx_serial,
  output logic [7:0]      rx_data,
  output logic            rx_is_k,
  output logic            rx_invalid,
  output logic            rx_valid,
  output logic [3:0]      lane_sync,
  output logic            mode_4x,
  output logic            link_up
);
  // Ones in a six-bit value
  function automatic logic [2:0] popc(input logic [5:0] v);
    popc = '0;
    for (int i = 0; i < 6; i++)
      popc = popc + 3'(v[i]);
  endfunction

  // Disparity at the end of a sub-block
  function automatic logic sub_rd(input logic [5:0] v, input logic six,
                                  input logic rd);
    logic [2:0] n;
    logic [2:0] half;
    n    = popc(v);
    half = six ? 3'h3 : 3'h2;
    if (n > half)
      sub_rd = 1'b1;
    else if (n < half)
      sub_rd = 1'b0;
    else if (six ? (v == 6'h07) : (v[3:0] == 4'h3))
      sub_rd = 1'b1;
    else if (six ? (v == 6'h38) : (v[3:0] == 4'hc))
      sub_rd = 1'b0;
    else
      sub_rd = rd;
  endfunction

  // Character is one of the defined data or special characters
  function automatic logic char_ok(input logic [8:0] ch);
    logic [4:0] x;
    x = ch[4:0];
    char_ok = !ch[8] || (x == 5'h1c) ||
              ((ch[7:5] == 3'h7) &&
               (x == 5'h17 || x == 5'h1b || x == 5'h1d || x == 5'h1e));
  endfunction

  // Encode one character: result is new disparity and code-group
  function automatic logic [10:0] enc(input logic [8:0] ch,
                                      input logic rd);
    logic [4:0] x;
    logic [2:0] y;
    logic       k28;
    logic       rdm;
    logic       alt;
    logic [5:0] b6;
    logic [3:0] b4;
    x   = ch[4:0];
    y   = ch[7:5];
    k28 = ch[8] && (x == 5'h1c);
    b6  = k28 ? slcs_pkg::K28_6B : slcs_pkg::ENC6[x];
    if (rd && (popc(b6) != 3'h3 || b6 == 6'h38))
      b6 = ~b6;
    rdm = sub_rd(b6, 1'b1, rd);
    alt = (y == 3'h7) && (ch[8] ||
          (!rdm && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
          (rdm && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
    b4  = alt ? slcs_pkg::ENC4_A7 : slcs_pkg::ENC4[y];
    if ((rdm || k28) && (popc({2'h0, b4}) != 3'h2 || b4 == 4'hc))
      b4 = ~b4;
    if (k28 && !rdm)
      b4 = ~b4;
    enc = {sub_rd({2'h0, b4}, 1'b0, rdm), b6, b4};
  endfunction

  // Decode by matching against the selected disparity column
  function automatic logic [9:0] dec(input logic [9:0] cg,
                                     input logic rd);
    logic [10:0] e;
    dec = {1'b0, 9'h000};
    for (int i = 0; i < 512; i++)
    begin
      e = enc(9'(i), rd);
      if (char_ok(9'(i)) && e[9:0] == cg)
        dec = {1'b1, 9'(i)};
    end
  endfunction

  // Queued character is part of the idle sequence
  function automatic logic is_idle(input logic [9:0] q);
    is_idle = !q[9] && (q[8:0] == slcs_pkg::K_SYNC ||
                        q[8:0] == slcs_pkg::K_ALIGN);
  endfunction

  // Transmit side state
  logic [3:0]        bit_cnt_r;       // Bit position within code-group
  logic              strobe;          // One cycle per code-group
  logic              q_v;             // Queue has a character
  logic [8:0]        q_d;             // Queue head character
  logic              pop;             // Take queue head
  logic [8:0]        col_r [4];       // Column being gathered
  logic [2:0]        col_cnt_r;       // Characters gathered
  logic              col_full;        // Column ready to send
  logic              send;            // Column launched this cycle
  logic [slcs_pkg::IDLE_W-1:0] idle_cnt_r; // Idle column counter
  logic [8:0]        idle_ch;         // Idle character for all lanes
  logic              tx_idle_r;       // Last launch was idle
  logic              tx_started_r;    // A code-group has been sent
  logic [8:0]        tx_ch [4];       // Character per lane
  logic [9:0]        tx_code [4];     // Code-group per lane
  logic [3:0]        tx_rd_nxt;       // Disparity after code-group
  logic [3:0]        tx_rd_r;         // Encoder disparity per lane
  logic [9:0]        tx_sh_r [4];     // Serializer per lane
  // Receive side state
  logic [9:0]        rx_sh_r [4];     // Deserializer window per lane
  logic [3:0]        rx_cnt_r [4];    // Bits since boundary
  logic [3:0]        rx_rd_r;         // Decoder disparity per lane
  logic [3:0]        lane_sync_r;     // Lane word-locked
  logic [3:0]        comma;           // Comma at window head
  logic [3:0]        emit;            // Complete code-group
  logic [9:0]        dec_q [4];       // Decode result
  logic [3:0]        dec_rd;          // Disparity after decode
  logic [3:0]        dq_wv;           // Deskew queue write
  logic [3:0]        dq_rdy;          // Deskew queue space
  logic [9:0]        dq_wd [4];       // Deskew queue data
  logic [3:0]        hv;              // Deskew head valid
  logic [9:0]        hd [4];          // Deskew head data
  logic [3:0]        dq_pop;          // Deskew head taken
  logic              overflow;        // A lane queue overflowed
  logic              all_a;           // All heads alignment chars
  logic              any_a;           // Some head alignment char
  logic              aligned_r;       // Lanes deskewed
  logic              col_take;        // Column moved to output
  logic [9:0]        out_col_r [4];   // Column being destriped
  logic [2:0]        out_left_r;      // Characters left in column
  logic [1:0]        out_idx_r;       // Next lane to deliver
  logic              mode_4x_r;       // Four lane operation
  logic [7:0]        rx_data_r;       // Delivered byte
  logic              rx_k_r;          // Delivered flag
  logic              rx_inv_r;        // Delivered invalid marker
  logic              rx_valid_r;      // Delivered strobe

  // Transmit character queue
  slcs_fifo #(.W(slcs_pkg::CHAR_W), .D(slcs_pkg::TXQ_DEPTH)) u_txq (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   ({tx_is_k, tx_data}),
    .out_valid (q_v),
    .out_ready (pop),
    .out_data  (q_d)
  );

  // Code-group rate divider
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      bit_cnt_r <= '0;
    else if (strobe)
      bit_cnt_r <= '0;
    else
      bit_cnt_r <= bit_cnt_r + 1'b1;
  end
  assign strobe   = (bit_cnt_r == 4'(slcs_pkg::CG_CYCLES - 1));

  // Column gathering: four characters or one in one-lane mode
  assign col_full = (col_cnt_r >= (mode_4x_r ? 3'h4 : 3'h1));
  assign send     = strobe && col_full;
  assign pop      = q_v && (!col_full || send);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      col_cnt_r <= '0;
      for (int l = 0; l < 4; l++)
        col_r[l] <= '0;
    end
    else
    begin
      if (send)
        col_cnt_r <= pop ? 3'h1 : 3'h0;
      else if (pop)
        col_cnt_r <= col_cnt_r + 1'b1;
      if (pop)
        col_r[send ? 2'h0 : col_cnt_r[1:0]] <= q_d;
    end
  end

  // Idle sequence: sync characters with periodic alignment columns
  assign idle_ch = (idle_cnt_r == '0) ? slcs_pkg::K_ALIGN : slcs_pkg::K_SYNC;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      idle_cnt_r   <= '0;
      tx_idle_r    <= 1'b1;
      tx_started_r <= 1'b0;
    end
    else if (strobe)
    begin
      if (!col_full)
        idle_cnt_r <= idle_cnt_r + 1'b1;
      tx_idle_r    <= !col_full;
      tx_started_r <= 1'b1;
    end
  end

  // Per-lane character choice and encoding
  always_comb
  begin
    for (int l = 0; l < 4; l++)
    begin
      if (col_full && (l == 0 || mode_4x_r))
        tx_ch[l] = col_r[l];
      else
        tx_ch[l] = idle_ch;
      {tx_rd_nxt[l], tx_code[l]} = enc(tx_ch[l], tx_rd_r[l]);
    end
  end

  // Serializers and encoder disparity, bit a leaves first
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_rd_r <= {4{slcs_pkg::RD_NEG}};
      for (int l = 0; l < 4; l++)
        tx_sh_r[l] <= '0;
    end
    else
      for (int l = 0; l < 4; l++)
        if (strobe)
        begin
          tx_sh_r[l] <= tx_code[l];
          tx_rd_r[l] <= tx_rd_nxt[l];
        end
        else
          tx_sh_r[l] <= {tx_sh_r[l][8:0], 1'b0};
  end
  always_comb
  begin
    for (int l = 0; l < 4; l++)
      tx_serial[l] = tx_sh_r[l][9];
  end

  // Receive window, comma search and decode per lane
  always_comb
  begin
    for (int l = 0; l < 4; l++)
    begin
      comma[l]  = (rx_sh_r[l][9:3] == slcs_pkg::COMMA_P) ||
                  (rx_sh_r[l][9:3] == slcs_pkg::COMMA_N);
      emit[l]   = comma[l] || (rx_cnt_r[l] == 4'(slcs_pkg::CG_W - 1));
      dec_q[l]  = dec(rx_sh_r[l], rx_rd_r[l]);
      dec_rd[l] = sub_rd({2'h0, rx_sh_r[l][3:0]}, 1'b0,
                         sub_rd(rx_sh_r[l][9:4], 1'b1, rx_rd_r[l]));
      dq_wd[l]  = {!dec_q[l][9], dec_q[l][8:0]};
      dq_wv[l]  = emit[l] && (lane_sync_r[l] || comma[l]);
    end
  end

  // Deserializer, boundary counter, decoder disparity, lane lock
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_rd_r     <= {4{slcs_pkg::RD_NEG}};
      lane_sync_r <= '0;
      for (int l = 0; l < 4; l++)
      begin
        rx_sh_r[l]  <= '0;
        rx_cnt_r[l] <= '0;
      end
    end
    else
      for (int l = 0; l < 4; l++)
      begin
        rx_sh_r[l] <= {rx_sh_r[l][8:0], rx_serial[l]};
        rx_cnt_r[l] <= emit[l] ? 4'h0 : rx_cnt_r[l] + 1'b1;
        if (emit[l])
        begin
          rx_rd_r[l] <= dec_rd[l];
          if (comma[l])
            lane_sync_r[l] <= 1'b1;
          else if (!dec_q[l][9])
            lane_sync_r[l] <= 1'b0;
        end
      end
  end

  // Lane deskew queues
  for (genvar g = 0; g < 4; g++)
  begin : g_dsk
    slcs_fifo #(.W(slcs_pkg::QCHAR_W), .D(slcs_pkg::DSK_DEPTH)) u_dsk (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (dq_wv[g]),
      .in_ready  (dq_rdy[g]),
      .in_data   (dq_wd[g]),
      .out_valid (hv[g]),
      .out_ready (dq_pop[g]),
      .out_data  (hd[g])
    );
  end
  assign overflow = |(dq_wv & ~dq_rdy);

  // Alignment search and column hand-off
  always_comb
  begin
    all_a = 1'b1;
    any_a = 1'b0;
    for (int l = 0; l < 4; l++)
    begin
      all_a = all_a && (hd[l] == {1'b0, slcs_pkg::K_ALIGN});
      any_a = any_a || (hd[l] == {1'b0, slcs_pkg::K_ALIGN});
    end
    if (mode_4x_r)
      col_take = aligned_r && (&hv) && (out_left_r == 3'h0);
    else
      col_take = hv[0] && (out_left_r == 3'h0);
    for (int l = 0; l < 4; l++)
      if (!mode_4x_r)
        dq_pop[l] = (l == 0) ? col_take : hv[l];
      else if (!aligned_r)
        dq_pop[l] = hv[l] && (hd[l] != {1'b0, slcs_pkg::K_ALIGN});
      else
        dq_pop[l] = col_take;
  end

  // Lane alignment state
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      aligned_r <= 1'b0;
    else if (!mode_4x_r || overflow)
      aligned_r <= 1'b0;
    else if (!aligned_r)
      aligned_r <= (&hv) && all_a;
    else if (col_take && any_a && !all_a)
      aligned_r <= 1'b0;
  end

  // Destriping: deliver lane 0..3 of each column, lane 0 only in one-lane mode, drop idle characters
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      out_left_r <= '0;
      out_idx_r  <= '0;
      rx_valid_r <= 1'b0;
      rx_data_r  <= '0;
      rx_k_r     <= 1'b0;
      rx_inv_r   <= 1'b0;
      for (int l = 0; l < 4; l++)
        out_col_r[l] <= '0;
    end
    else
    begin
      rx_valid_r <= (out_left_r != 3'h0) &&
                    !is_idle(out_col_r[out_idx_r]);
      {rx_inv_r, rx_k_r, rx_data_r} <= out_col_r[out_idx_r];
      if (col_take)
      begin
        out_col_r  <= hd;
        out_left_r <= mode_4x_r ? 3'h4 : 3'h1;
        out_idx_r  <= '0;
      end
      else if (out_left_r != 3'h0)
      begin
        out_left_r <= out_left_r - 1'b1;
        out_idx_r  <= out_idx_r + 1'b1;
      end
    end
  end

  // Link width and state
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mode_4x_r <= 1'b0;
    else
      mode_4x_r <= !force_1x && (&lane_sync_r);
  end

  assign rx_data    = rx_data_r;
  assign rx_is_k    = rx_k_r;
  assign rx_invalid = rx_inv_r;
  assign rx_valid   = rx_valid_r;
  assign lane_sync  = lane_sync_r;
  assign mode_4x    = mode_4x_r;
  assign link_up    = lane_sync_r[0];

  // Checks
  a_stripe_bound: assert property (@(posedge clk) disable iff (!nrst)
    col_cnt_r <= 3'h4) else $error("column count above four");
  a_one_lane_idle: assert property (@(posedge clk) disable iff (!nrst)
    !mode_4x_r |-> tx_ch[1] == idle_ch) else $error("lane 1 used in 1x");
  a_one_lane_fill: assert property (@(posedge clk) disable iff (!nrst)
    !mode_4x_r && pop && !send |-> col_cnt_r == 3'h0)
    else $error("1x character placed off lane 0");
  a_idle_fill: assert property (@(posedge clk) disable iff (!nrst)
    strobe && !col_full |=> tx_idle_r && tx_sh_r[2] == $past(tx_code[2]))
    else $error("idle not inserted");
  a_ser_order: assert property (@(posedge clk) disable iff (!nrst)
    strobe |-> ##1 (tx_serial[0] == $past(tx_code[0][9]))
               ##1 (tx_serial[0] == $past(tx_code[0][8], 2)))
    else $error("serial bit order wrong");
  a_cg_balance: assert property (@(posedge clk) disable iff (!nrst)
    strobe |-> (4'(popc(tx_code[0][9:4])) + 4'(popc({2'h0, tx_code[0][3:0]})))
               inside {4'h4, 4'h5, 4'h6}) else $error("unbalanced code-group");
  a_rd_heavy: assert property (@(posedge clk) disable iff (!nrst)
    strobe && (4'(popc(tx_code[0][9:4])) +
               4'(popc({2'h0, tx_code[0][3:0]}))) == 4'h6
    |-> !tx_rd_r[0] ##1 tx_rd_r[0]) else $error("disparity not tracked");
  a_tx_rd_start: assert property (@(posedge clk) disable iff (!nrst)
    !tx_started_r |-> tx_rd_r == 4'h0) else $error("start disparity");
  a_comma_lock: assert property (@(posedge clk) disable iff (!nrst)
    comma[0] |=> rx_cnt_r[0] == 4'h0 && lane_sync_r[0])
    else $error("comma not aligned");
  a_bad_cg: assert property (@(posedge clk) disable iff (!nrst)
    emit[0] && !comma[0] && !dec_q[0][9] |=> !lane_sync_r[0])
    else $error("invalid code-group ignored");
  a_no_idle_up: assert property (@(posedge clk) disable iff (!nrst)
    rx_valid |-> !(!rx_invalid && rx_is_k &&
      (rx_data == slcs_pkg::K_SYNC[7:0] || rx_data == slcs_pkg::K_ALIGN[7:0])))
    else $error("idle character delivered");
  a_align_cols: assert property (@(posedge clk) disable iff (!nrst)
    $rose(aligned_r) |-> $past(all_a) && mode_4x_r)
    else $error("aligned without alignment column");
endmodule // slcs_top
`default_nettype wire
